// file: ucc_pkg.sv
// ucc_pkg: constants shared by the serial control block.
// assumes an AXI4-Lite master with 32-bit data and byte addressing.
`default_nettype none
package ucc_pkg;
    localparam int AXI_ADDR_W = 8;
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_CTRL_ONE = 6'h02;
    localparam logic [5:0] IDX_CTRL_TWO = 6'h03;
    localparam logic [5:0] IDX_STATE = 6'h08;
    localparam logic [7:0] ADDR_CTRL_ONE = {IDX_CTRL_ONE, 2'h0};
    localparam logic [7:0] ADDR_CTRL_TWO = {IDX_CTRL_TWO, 2'h0};
    localparam logic [7:0] ADDR_STATE = {IDX_STATE, 2'h0};
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    // control one fields
    localparam int B_LOOP_SELECT = 7;
    localparam int B_HALT_IN_WAIT = 6;
    localparam int B_RECEIVER_SOURCE = 5;
    localparam int B_NINE_BITS = 4;
    localparam int B_WAKE_ADDR = 3;
    localparam int B_IDLE_COUNT_START = 2;
    localparam int B_PARITY_ON = 1;
    localparam int B_PARITY_ODD = 0;
    // control two fields
    localparam int B_TX_EMPTY_IRQ_EN = 7;
    localparam int B_TX_DONE_IRQ_EN = 6;
    localparam int B_RX_FULL_IRQ_EN = 5;
    localparam int B_IDLE_IRQ_EN = 4;
    localparam int B_TX_ON = 3;
    localparam int B_RX_ON = 2;
    // consecutive ones that make an idle character
    localparam logic [3:0] IDLE_ONES_EIGHT = 4'hA;
    localparam logic [3:0] IDLE_ONES_NINE = 4'hB;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ucc_pkg
`default_nettype wire

// file: ucc_top.sv
// ucc_top: control registers, line routing, frame format, parity, idle
// detection and interrupt gating of the serial transceiver.
// assumes the shifters, baud divider and status flags live outside on clk_sys;
// rx_pin and txd_pin_in are asynchronous pins.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: loop select cuts the receive pin and feeds transmitter output to the receiver.
// RQ2: software enables both transmitter and receiver when using loop operation.
// RQ3: receiver source picks internal loop (0) or single-wire transmit pin (1).
// RQ4: halt in wait stops the serial logic during processor wait mode.
// RQ5: character length picks eight or nine data bits, one start, one stop.
// RQ6: wakeup on idle line (0) or on address mark in the data msb (1).
// RQ7: idle ones count starts after start bit (0) or after stop bit (1).
// RQ8: parity enable puts parity in the data msb, generated and checked.
// RQ9: parity odd selects odd parity, else even parity.
// RQ10: transmit empty flag raises interrupt only with its enable set.
// RQ11: transmission finished flag raises interrupt only with its enable set.
// RQ12: receive full and overrun raise interrupt only with receive enable set.
// RQ13: idle flag raises interrupt only with idle enable set.
// RQ14: transmitter enable turns transmitter on and takes the transmit pin.
// RQ15: setting transmitter enable queues an idle preamble.
// RQ16: receiver enable switches the receiver on.
// RQ17: both control registers are readable and writable at any time.
// RQ18: idle after 10 ones for eight bits, 11 ones for nine bits.
// RQ19: in halted wait a transfer freezes and resumes; reset aborts it.
// RQ20: interrupt request is the OR of every flag ANDed with its enable.
// RQ21: format, parity and routing changes apply only at frame boundaries.
module ucc_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cpu_wait,
    input wire logic bit_tick,
    input wire logic tx_serial,
    input wire logic tx_idle,
    input wire logic rx_idle,
    input wire logic [8:0] tx_data,
    input wire logic [8:0] rx_data,
    input wire logic rx_data_valid,
    input wire logic rx_stop_done,
    input wire logic tx_buf_empty,
    input wire logic tx_finished,
    input wire logic rx_buf_full,
    input wire logic rx_overrun,
    input wire logic idle_flag,
    input wire logic rx_pin,
    input wire logic txd_pin_in,
    output logic txd_pin_out,
    output logic txd_pin_oe_n,
    output logic module_run,
    output logic bit_tick_run,
    output logic tx_enable,
    output logic rx_enable,
    output logic preamble_req,
    output logic rx_line,
    output logic frame_nine_bits,
    output logic parity_on,
    output logic parity_odd,
    output logic tx_parity_bit,
    output logic parity_error,
    output logic idle_detect,
    output logic wake_event,
    output logic irq
);
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [7:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
    logic wstrb_reg, wstrb_next, bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] ctrl_one_reg, ctrl_one_next, ctrl_two_reg, ctrl_two_next;
    logic [6:0] cfg_reg, cfg_next;
    logic rxp_s1_reg, rxp_s2_reg, txp_s1_reg, txp_s2_reg;
    logic rx_line_reg, rx_line_next, tx_on_d_reg, tx_on_d_next;
    logic preamble_reg, preamble_next, irq_reg, irq_next;
    logic txpar_reg, txpar_next, perr_reg, perr_next;
    logic [3:0] idle_cnt_reg, idle_cnt_next;
    logic idle_armed_reg, idle_armed_next, idle_done_reg, idle_done_next;
    logic idle_det_reg, idle_det_next, wake_reg, wake_next;
    logic write_fire, run, tick, cfg_loop, cfg_receiver_source, cfg_nine, cfg_wake, cfg_ilt;
    logic cfg_pon, cfg_podd, rx_par_calc, tx_par_calc, rx_msb;
    logic [8:0] par_mask;
    logic [3:0] idle_thresh;

    // latched format; cfg bits follow control one order without halt_in_wait
    assign cfg_loop = cfg_reg[6];
    assign cfg_receiver_source = cfg_reg[5];
    assign cfg_nine = cfg_reg[4];
    assign cfg_wake = cfg_reg[3];
    assign cfg_ilt = cfg_reg[2];
    assign cfg_pon = cfg_reg[1];
    assign cfg_podd = cfg_reg[0];

    assign run = !(ctrl_one_reg[ucc_pkg::B_HALT_IN_WAIT] && cpu_wait); // see RQ4
    // freezing the bit rate enable holds every shifter where it stands
    assign tick = bit_tick && run; // see RQ19
    assign write_fire = aw_held_reg && w_held_reg && !bvalid_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // register bus, accepted in any operating state; new requests wait while a response is pending
    always_comb begin // see RQ17
        aw_held_next = aw_held_reg;
        awaddr_next = awaddr_reg;
        w_held_next = w_held_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        ctrl_one_next = ctrl_one_reg;
        ctrl_two_next = ctrl_two_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata[7:0];
            wstrb_next = s_axi_wstrb[0];
        end
        if (write_fire) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = ucc_pkg::RESP_OKAY;
            case (awaddr_reg)
                ucc_pkg::ADDR_CTRL_ONE: begin
                    if (wstrb_reg) begin
                        ctrl_one_next = wdata_reg;
                    end
                end
                ucc_pkg::ADDR_CTRL_TWO: begin
                    if (wstrb_reg) begin
                        ctrl_two_next = wdata_reg;
                    end
                end
                ucc_pkg::ADDR_STATE: begin
                end
                default: begin
                    bresp_next = ucc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = ucc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                ucc_pkg::ADDR_CTRL_ONE: rdata_next = {24'h00_0000, ctrl_one_reg};
                ucc_pkg::ADDR_CTRL_TWO: rdata_next = {24'h00_0000, ctrl_two_reg};
                ucc_pkg::ADDR_STATE: rdata_next = {16'h0000, 1'b0, cfg_reg,
                    2'h0, idle_armed_reg, rx_line_reg, tx_enable, rx_enable, irq_reg, run};
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = ucc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ucc_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= ucc_pkg::RESP_OKAY;
            ctrl_one_reg <= ucc_pkg::RST_CTRL_ONE;
            ctrl_two_reg <= ucc_pkg::RST_CTRL_TWO;
        end else begin
            aw_held_reg <= aw_held_next;
            awaddr_reg <= awaddr_next;
            w_held_reg <= w_held_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ctrl_one_reg <= ctrl_one_next;
            ctrl_two_reg <= ctrl_two_next;
        end
    end

    // pin synchronisers; only the second stage is read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxp_s1_reg <= 1'b1;
            rxp_s2_reg <= 1'b1;
            txp_s1_reg <= 1'b1;
            txp_s2_reg <= 1'b1;
        end else begin
            rxp_s1_reg <= rx_pin;
            rxp_s2_reg <= rxp_s1_reg;
            txp_s1_reg <= txd_pin_in;
            txp_s2_reg <= txp_s1_reg;
        end
    end

    assign idle_thresh = cfg_nine ? ucc_pkg::IDLE_ONES_NINE : ucc_pkg::IDLE_ONES_EIGHT; // see RQ18
    assign par_mask = cfg_nine ? 9'h0FF : 9'h07F; // see RQ5
    assign tx_par_calc = (^(tx_data & par_mask)) ^ cfg_podd; // see RQ9
    assign rx_par_calc = (^(rx_data & par_mask)) ^ cfg_podd; // see RQ9
    assign rx_msb = cfg_nine ? rx_data[8] : rx_data[7]; // see RQ6

    always_comb begin
        cfg_next = cfg_reg;
        // a frame already shifting keeps the format it started with
        if (tx_idle && rx_idle) begin // see RQ21
            cfg_next = {ctrl_one_reg[ucc_pkg::B_LOOP_SELECT], ctrl_one_reg[5:0]};
        end
        // see RQ1 RQ3
        if (!cfg_loop) begin
            rx_line_next = rxp_s2_reg;
        end else if (cfg_receiver_source) begin
            rx_line_next = txp_s2_reg;
        end else begin
            rx_line_next = tx_serial;
        end
        tx_on_d_next = ctrl_two_reg[ucc_pkg::B_TX_ON];
        preamble_next = ctrl_two_reg[ucc_pkg::B_TX_ON] && !tx_on_d_reg; // see RQ15
        txpar_next = tx_par_calc; // see RQ8
        perr_next = rx_data_valid && run && cfg_pon && (rx_par_calc != rx_msb); // see RQ8
        irq_next = (ctrl_two_reg[ucc_pkg::B_TX_EMPTY_IRQ_EN] && tx_buf_empty) // see RQ10 RQ20
            || (ctrl_two_reg[ucc_pkg::B_TX_DONE_IRQ_EN] && tx_finished) // see RQ11
            || (ctrl_two_reg[ucc_pkg::B_RX_FULL_IRQ_EN] && (rx_buf_full || rx_overrun)) // see RQ12
            || (ctrl_two_reg[ucc_pkg::B_IDLE_IRQ_EN] && idle_flag); // see RQ13
        idle_cnt_next = idle_cnt_reg;
        idle_armed_next = idle_armed_reg;
        idle_done_next = idle_done_reg;
        idle_det_next = 1'b0;
        if (!rx_enable) begin
            idle_cnt_next = 4'h0;
            idle_armed_next = 1'b0;
            idle_done_next = 1'b0;
        end else if (rx_stop_done && run) begin
            idle_armed_next = 1'b1; // see RQ7
            idle_cnt_next = 4'h0;
        end else if (tick) begin
            if (!rx_line_reg) begin
                idle_cnt_next = 4'h0;
                idle_armed_next = 1'b0;
                idle_done_next = 1'b0;
            end else if ((!cfg_ilt || idle_armed_reg) && !idle_done_reg) begin // see RQ7
                idle_cnt_next = idle_cnt_reg + 4'h1;
                if (idle_cnt_reg + 4'h1 == idle_thresh) begin // see RQ18
                    idle_det_next = 1'b1;
                    idle_done_next = 1'b1;
                end
            end
        end
        wake_next = cfg_wake ? (rx_data_valid && run && rx_msb) : idle_det_next; // see RQ6
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= 7'h00;
            rx_line_reg <= 1'b1;
            tx_on_d_reg <= 1'b0;
            preamble_reg <= 1'b0;
            txpar_reg <= 1'b0;
            perr_reg <= 1'b0;
            irq_reg <= 1'b0;
            idle_cnt_reg <= 4'h0;
            idle_armed_reg <= 1'b0;
            idle_done_reg <= 1'b0;
            idle_det_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            rx_line_reg <= rx_line_next;
            tx_on_d_reg <= tx_on_d_next;
            preamble_reg <= preamble_next;
            txpar_reg <= txpar_next;
            perr_reg <= perr_next;
            irq_reg <= irq_next;
            idle_cnt_reg <= idle_cnt_next;
            idle_armed_reg <= idle_armed_next;
            idle_done_reg <= idle_done_next;
            idle_det_reg <= idle_det_next;
            wake_reg <= wake_next;
        end
    end

    assign module_run = run;
    assign bit_tick_run = tick; // see RQ19
    assign tx_enable = ctrl_two_reg[ucc_pkg::B_TX_ON]; // see RQ14
    assign rx_enable = ctrl_two_reg[ucc_pkg::B_RX_ON]; // see RQ16
    // pin idles high and is released while the transmitter is off
    assign txd_pin_out = tx_enable ? tx_serial : 1'b1; // see RQ14
    assign txd_pin_oe_n = !tx_enable; // see RQ14
    assign preamble_req = preamble_reg;
    assign rx_line = rx_line_reg;
    assign frame_nine_bits = cfg_nine; // see RQ5
    assign parity_on = cfg_pon; // see RQ8
    assign parity_odd = cfg_podd; // see RQ9
    assign tx_parity_bit = txpar_reg;
    assign parity_error = perr_reg;
    assign idle_detect = idle_det_reg;
    assign wake_event = wake_reg;
    assign irq = irq_reg;
endmodule : ucc_top
`default_nettype wire

// file: ucc_chk.sv
// ucc_chk: port-level assertions for ucc_top.
// assumes one clock domain, clk_sys, with async active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module ucc_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tx_enable,
    input wire logic txd_pin_out,
    input wire logic txd_pin_oe_n,
    input wire logic tx_serial,
    input wire logic module_run,
    input wire logic cpu_wait,
    input wire logic bit_tick,
    input wire logic bit_tick_run,
    input wire logic preamble_req,
    input wire logic tx_parity_bit,
    input wire logic [8:0] tx_data,
    input wire logic frame_nine_bits,
    input wire logic parity_odd,
    input wire logic parity_on,
    input wire logic parity_error,
    input wire logic rx_data_valid,
    input wire logic rx_enable,
    input wire logic idle_detect,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_arready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_txd_idle_high: assert property (!tx_enable |-> txd_pin_out && txd_pin_oe_n)
        else $error("transmit pin not released");
    a_txd_driven: assert property (tx_enable |-> !txd_pin_oe_n && txd_pin_out == tx_serial)
        else $error("transmit pin not driven by shifter");
    a_wait_stop: assert property (!module_run |-> cpu_wait && !bit_tick_run)
        else $error("module halted outside wait");
    a_tick_gate: assert property (bit_tick && module_run |-> bit_tick_run)
        else $error("bit tick lost while running");
    a_preamble_pulse: assert property ($rose(tx_enable) |=> preamble_req ##1 !preamble_req)
        else $error("no single preamble pulse");
    a_tx_parity: assert property ($past(rst_n) |-> tx_parity_bit == ($past(parity_odd) ^
        ($past(frame_nine_bits) ? ^$past(tx_data[7:0]) : ^$past(tx_data[6:0]))))
        else $error("transmit parity wrong");
    a_perr_cause: assert property (parity_error |-> $past(rx_data_valid) && $past(parity_on))
        else $error("parity error without checked character");
    a_rx_off_quiet: assert property (!rx_enable ##1 !rx_enable |-> !idle_detect)
        else $error("idle seen with receiver off");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
endmodule : ucc_chk
bind ucc_top ucc_chk chk_u (.clk_sys, .rst_n, .tx_enable, .txd_pin_out, .txd_pin_oe_n,
    .tx_serial, .module_run, .cpu_wait, .bit_tick, .bit_tick_run, .preamble_req, .tx_parity_bit,
    .tx_data, .frame_nine_bits, .parity_odd, .parity_on, .parity_error, .rx_data_valid,
    .rx_enable, .idle_detect, .s_axi_rvalid, .s_axi_arready);
`default_nettype wire

// file: ucc_peer.sv
// ucc_peer: remote serial peer on the receive and transmit pins.
// assumes the bench sets the level the peer puts on the receive line.
`timescale 1ns/1ps
`default_nettype none
module ucc_peer (
    input wire logic clk_sys,
    input wire logic line_level,
    input wire logic txd_pin_out,
    input wire logic txd_pin_oe_n,
    output logic rx_pin,
    output logic txd_pin_in
);
    // transmit wire has a pull-up, so a released pin reads high
    assign txd_pin_in = txd_pin_oe_n ? 1'b1 : txd_pin_out;
    always_ff @(posedge clk_sys) begin
        rx_pin <= line_level;
    end
endmodule : ucc_peer
`default_nettype wire

// file: uart_control_config_test.sv
// uart_control_config_test: self-checking bench for ucc_top.
// assumes ucc_peer on the pins and an AXI4-Lite master in this module.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module uart_control_config_test;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} ucc_bus_t;
    typedef struct {logic [7:0] c1; logic [7:0] c2; logic ts; logic ln; logic q;} ucc_route_t;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic cpu_wait = 0, bit_tick = 0, tx_serial = 1, tx_idle = 1, rx_idle = 1, line_level = 1;
    logic rx_data_valid = 0, rx_stop_done = 0, tx_buf_empty = 0, tx_finished = 0;
    logic rx_buf_full = 0, rx_overrun = 0, idle_flag = 0;
    logic [8:0] tx_data = '0, rx_data = '0;
    logic rx_pin, txd_pin_in, txd_pin_out, txd_pin_oe_n, module_run, bit_tick_run, tx_enable;
    logic rx_enable, preamble_req, rx_line, frame_nine_bits, parity_on, parity_odd;
    logic tx_parity_bit, parity_error, idle_detect, wake_event, irq;
    logic [31:0] rd;
    int failures = 0, check_count = 0, cnt;
    ucc_bus_t bus [4] = '{'{ucc_pkg::ADDR_CTRL_ONE, 32'h1234_5625, 32'h0000_0025, 2'h0},
        '{ucc_pkg::ADDR_CTRL_TWO, 32'h0000_00F0, 32'h0000_00F0, 2'h0},
        '{ucc_pkg::ADDR_CTRL_ONE, 32'h0000_005A, 32'h0000_005A, 2'h0},
        '{8'h10, 32'h0000_0077, 32'h0000_0000, 2'h2}};
    ucc_route_t rt [6] = '{'{8'h00, 8'h0C, 1, 0, 0}, '{8'h80, 8'h0C, 0, 1, 0},
        '{8'h80, 8'h0C, 1, 0, 1}, '{8'hA0, 8'h0C, 0, 1, 0}, '{8'hA0, 8'h0C, 1, 0, 1},
        '{8'h20, 8'h04, 1, 0, 0}};
    logic [7:0] idl_c1 [4] = '{8'h00, 8'h10, 8'h04, 8'h04};
    int idl_n [4] = '{10, 11, 0, 10};
    logic idl_s [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0] irq_en [5] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10};
    always #2.5 clk_sys = ~clk_sys;
    ucc_top dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu_wait, .bit_tick, .tx_serial, .tx_idle, .rx_idle, .tx_data, .rx_data,
        .rx_data_valid, .rx_stop_done, .tx_buf_empty, .tx_finished, .rx_buf_full, .rx_overrun,
        .idle_flag, .rx_pin, .txd_pin_in, .txd_pin_out, .txd_pin_oe_n, .module_run,
        .bit_tick_run, .tx_enable, .rx_enable, .preamble_req, .rx_line, .frame_nine_bits,
        .parity_on, .parity_odd, .tx_parity_bit, .parity_error, .idle_detect, .wake_event, .irq);
    ucc_peer peer_u (.clk_sys, .line_level, .txd_pin_out, .txd_pin_oe_n, .rx_pin, .txd_pin_in);
    task automatic stop_test;
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // bready and rready stay high throughout, so only the valids move
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 64);
        r = s_axi_bresp;
        if (!s_axi_bvalid) begin failures++; stop_test(); end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 64);
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (!s_axi_rvalid) begin failures++; stop_test(); end
    endtask : axi_rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi_wr(a, {24'h00_0000, d}, resp);
        `CHK("bresp", ucc_pkg::RESP_OKAY, resp)
    endtask : wr
    task automatic tick;
        bit_tick <= 1'b1;
        @(posedge clk_sys);
        bit_tick <= 1'b0;
        @(posedge clk_sys);
    endtask : tick
    // a zero bit first clears the count; stp marks a stop bit; stops at 14 ticks, 0 if none
    task automatic idle_ticks(input logic stp, output int c);
        c = 0;
        line_level <= 1'b0;
        repeat (5) @(posedge clk_sys);
        tick();
        line_level <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rx_stop_done <= stp;
        @(posedge clk_sys);
        rx_stop_done <= 1'b0;
        for (int k = 1; k <= 14 && c == 0; k++) begin
            tick();
            // the detect pulse stands only in the cycle after the counting tick
            if (idle_detect === 1'b1) begin
                c = k;
                `CHK("wake_event", 1'b1, wake_event)
            end
        end
    endtask : idle_ticks
    task automatic rx_char(input logic [8:0] d, input logic pe, input logic we);
        rx_data <= d;
        rx_data_valid <= 1'b1;
        @(posedge clk_sys);
        rx_data_valid <= 1'b0;
        @(posedge clk_sys);
        `CHK("parity_error", pe, parity_error)
        `CHK("wake_event", we, wake_event)
    endtask : rx_char
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        axi_rd(ucc_pkg::ADDR_CTRL_ONE, rd, resp);
        `CHK("reset one", {24'h00_0000, ucc_pkg::RST_CTRL_ONE}, rd)
        axi_rd(ucc_pkg::ADDR_CTRL_TWO, rd, resp);
        `CHK("reset two", {24'h00_0000, ucc_pkg::RST_CTRL_TWO}, rd)
        foreach (bus[i]) begin
            axi_wr(bus[i].a, bus[i].d, resp);
            `CHK("bresp", bus[i].r, resp)
            axi_rd(bus[i].a, rd, resp);
            `CHK("rdata", bus[i].q, rd)
            `CHK("rresp", bus[i].r, resp)
        end
        // loop rows keep both enables set, as loop operation requires
        foreach (rt[i]) begin
            wr(ucc_pkg::ADDR_CTRL_ONE, rt[i].c1);
            wr(ucc_pkg::ADDR_CTRL_TWO, rt[i].c2);
            tx_serial <= rt[i].ts;
            line_level <= rt[i].ln;
            repeat (6) @(posedge clk_sys);
            `CHK("rx_line", rt[i].q, rx_line)
            `CHK("txd_pin_oe_n", ~rt[i].c2[3], txd_pin_oe_n)
        end
        tx_idle <= 1'b0;
        wr(ucc_pkg::ADDR_CTRL_ONE, 8'h1B);
        `CHK("frame_nine_bits", 1'b0, frame_nine_bits)
        tx_idle <= 1'b1;
        tx_data <= 9'h003;
        // parity register lags the latched format by one cycle
        repeat (3) @(posedge clk_sys);
        `CHK("frame_nine_bits", 1'b1, frame_nine_bits)
        `CHK("parity_on", 1'b1, parity_on)
        `CHK("parity_odd", 1'b1, parity_odd)
        `CHK("tx_parity_bit", 1'b1, tx_parity_bit)
        rx_char(9'h003, 1'b1, 1'b0);
        rx_char(9'h103, 1'b0, 1'b1);
        wr(ucc_pkg::ADDR_CTRL_ONE, 8'h40);
        cpu_wait <= 1'b1;
        bit_tick <= 1'b1;
        @(posedge clk_sys);
        `CHK("module_run", 1'b0, module_run)
        `CHK("bit_tick_run", 1'b0, bit_tick_run)
        bit_tick <= 1'b0;
        wr(ucc_pkg::ADDR_CTRL_ONE, 8'h00);
        `CHK("module_run", 1'b1, module_run)
        cpu_wait <= 1'b0;
        wr(ucc_pkg::ADDR_CTRL_TWO, 8'h04);
        foreach (idl_c1[i]) begin
            wr(ucc_pkg::ADDR_CTRL_ONE, idl_c1[i]);
            idle_ticks(idl_s[i], cnt);
            `CHK("idle ticks", idl_n[i], cnt)
        end
        for (int i = 0; i < 5; i++) begin
            wr(ucc_pkg::ADDR_CTRL_TWO, ~irq_en[i] & 8'hF0);
            {tx_buf_empty, tx_finished, rx_buf_full, rx_overrun, idle_flag} <= 5'h10 >> i;
            repeat (3) @(posedge clk_sys);
            `CHK("irq masked", 1'b0, irq)
            wr(ucc_pkg::ADDR_CTRL_TWO, irq_en[i]);
            repeat (2) @(posedge clk_sys);
            `CHK("irq enabled", 1'b1, irq)
            {tx_buf_empty, tx_finished, rx_buf_full, rx_overrun, idle_flag} <= 5'h00;
        end
        // reset in mid-run must bring control register two back
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        axi_rd(ucc_pkg::ADDR_CTRL_TWO, rd, resp);
        `CHK("reset two", {24'h00_0000, ucc_pkg::RST_CTRL_TWO}, rd)
        stop_test();
    end
endmodule : uart_control_config_test
`default_nettype wire
